// *** rtl/onoff_sequencer_thermal_guard.sv ***
// On/off controller, four-resource sequencer, debounced wake pins, thermal guard
`timescale 1ns/100ps
module onoff_sequencer_thermal_guard (
	input wire logic clock,
	input wire logic srst,
	input wire onoff_pkg::analog_flags_t flags,
	input wire onoff_pkg::wake_cfg_t wake_cfg,
	input wire onoff_pkg::res_cfg_t [3:0] res_cfg,
	input wire logic [3:0] sw_enable,
	input wire logic bias_enable_bit,
	input wire logic [1:0] soft_reset_field,
	input wire logic soft_reset_write,
	input wire logic internal_wake_flag,
	input wire logic on_key_n,
	input wire logic charge_input,
	input wire logic gpio_wake,
	input wire logic gpio_manual_reset,
	input wire logic [1:0] temp_irq_mask,
	input wire logic [1:0] temp_irq_clear,
	output logic [3:0] res_on,
	output logic bias_request,
	output logic temp_alarm_low_status,
	output logic temp_alarm_high_status,
	output logic [1:0] temp_irq_pending,
	output logic temp_irq,
	output logic overtemp_blocked,
	output logic cold_reset_wake,
	output onoff_pkg::ctrl_state_t state
);
	import onoff_pkg::*;

	logic key_down;
	logic chg_clean;
	logic gpio_clean;
	logic key_prev;
	logic chg_prev;
	logic gpio_prev;
	logic [SEQ_W-1:0] timer;
	logic [1:0] slot;
	logic slot_tick;
	logic wake;
	logic shutdown_req;
	logic [1:0] alarm_prev;
	logic [1:0] alarm_now;
	logic [3:0] up_mask;
	logic [3:0] down_mask;

	debounce u_key (.clock(clock), .srst(srst), .raw(!on_key_n),
		.clean(key_down));
	debounce u_chg (.clock(clock), .srst(srst), .raw(charge_input),
		.clean(chg_clean));
	debounce u_gpio (.clock(clock), .srst(srst), .raw(gpio_wake),
		.clean(gpio_clean));

	// Key is debounced as its pressed level, so no false edge after reset
	always_ff @(posedge clock) begin
		if (srst) begin
			key_prev <= 1'b0;
			chg_prev <= 1'b0;
			gpio_prev <= 1'b0;
		end else begin
			key_prev <= key_down;
			chg_prev <= chg_clean;
			gpio_prev <= gpio_clean;
		end
	end

	assign wake = (wake_cfg.onkey_wake_enable && !key_prev && key_down)
		|| (wake_cfg.charge_wake_enable && !chg_prev && chg_clean)
		|| internal_wake_flag
		|| (wake_cfg.gpio_wake_enable && !gpio_prev && gpio_clean);

	// soft reset codes and manual resets
	assign shutdown_req = (soft_reset_write
		&& (soft_reset_field == SOFT_RESET_COLD
		|| soft_reset_field == SOFT_RESET_OFF))
		|| (wake_cfg.onkey_manual_reset_enable && key_down)
		|| (wake_cfg.gpio_manual_reset_enable && gpio_manual_reset);

	// Cold reset re-wakes via the internal flag outside this block
	always_ff @(posedge clock) begin
		if (srst) begin
			cold_reset_wake <= 1'b0;
		end else begin
			cold_reset_wake <= soft_reset_write
				&& soft_reset_field == SOFT_RESET_COLD;
		end
	end

	assign slot_tick = (timer == SLOT_CYCLES - 16'h0001);

	always_ff @(posedge clock) begin
		if (srst) begin
			timer <= '0;
			slot <= '0;
		end else if (state == st_power_up || state == st_power_down) begin
			if (slot_tick) begin
				timer <= '0;
				slot <= slot + 2'h1;
			end else begin
				timer <= timer + 16'h0001;
			end
		end else begin
			timer <= '0;
			slot <= '0;
		end
	end

	always_comb begin
		up_mask = '0;
		down_mask = '0;
		for (int i = 0; i < NUM_RES; i++) begin
			up_mask[i] = res_cfg[i].hw_sequenced
				&& res_cfg[i].up_slot == slot;
			down_mask[i] = res_cfg[i].hw_sequenced
				&& res_cfg[i].down_slot == slot;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			overtemp_blocked <= 1'b0;
		end else if (flags.overtemp_lockout) begin
			overtemp_blocked <= 1'b1;
		end else if (flags.temp_recovered) begin
			overtemp_blocked <= 1'b0;
		end
	end

	// Main controller
	always_ff @(posedge clock) begin
		if (srst) begin
			state <= st_standby;
		end else begin
			case (state)
			st_standby: begin
				if (bias_enable_bit) begin
					state <= st_bias_enable;
				end else if (wake && !overtemp_blocked) begin
					state <= st_bias_enable;
				end
			end
			st_bias_enable: begin
				if (flags.bias_ok) begin
					state <= bias_enable_bit ? st_sw_on : st_power_up;
				end
			end
			st_sw_on: begin
				if (flags.system_undervoltage_lockout
					|| flags.overtemp_lockout) begin
					state <= st_immediate_off;
				end else if (!bias_enable_bit) begin
					state <= st_bias_disable;
				end
			end
			st_power_up: begin
				if (slot_tick && slot == 2'h3) begin
					state <= st_hw_on;
				end
			end
			st_hw_on: begin
				if (flags.overtemp_lockout
					|| flags.system_undervoltage_lockout
					|| flags.system_overvoltage_lockout) begin
					state <= st_immediate_off;
				end else if (shutdown_req) begin
					state <= st_power_down;
				end
			end
			st_power_down: begin
				if (slot_tick && slot == 2'h3) begin
					state <= st_bias_disable;
				end
			end
			st_immediate_off: begin
				if (res_on == RES_OFF) begin
					state <= st_bias_disable;
				end
			end
			st_bias_disable: begin
				if (flags.bias_off_done) begin
					state <= st_standby;
				end
			end
			default: state <= st_standby;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			res_on <= RES_OFF;
		end else if (overtemp_blocked || state == st_immediate_off
			|| state == st_standby || state == st_bias_disable) begin
			res_on <= RES_OFF;
		end else if (state == st_sw_on) begin
			res_on <= sw_enable;
		end else if (state == st_power_up && slot_tick) begin
			res_on <= res_on | up_mask;
		end else if (state == st_power_down && slot_tick) begin
			res_on <= res_on & ~down_mask;
		end else if (state == st_hw_on) begin
			res_on <= res_on | (sw_enable & ~{res_cfg[3].hw_sequenced,
				res_cfg[2].hw_sequenced, res_cfg[1].hw_sequenced,
				res_cfg[0].hw_sequenced});
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			bias_request <= 1'b0;
		end else begin
			bias_request <= state != st_standby
				&& state != st_bias_disable;
		end
	end

	assign alarm_now = {flags.temp_alarm_high, flags.temp_alarm_low};

	always_ff @(posedge clock) begin
		if (srst) begin
			alarm_prev <= '0;
			temp_alarm_low_status <= 1'b0;
			temp_alarm_high_status <= 1'b0;
		end else begin
			alarm_prev <= alarm_now;
			temp_alarm_low_status <= alarm_now[0];
			temp_alarm_high_status <= alarm_now[1];
		end
	end

	// change events, set wins over clear
	always_ff @(posedge clock) begin
		if (srst) begin
			temp_irq_pending <= '0;
		end else begin
			temp_irq_pending <= (temp_irq_pending & ~temp_irq_clear)
				| (alarm_now ^ alarm_prev);
		end
	end

	// masks default applied outside; gate here
	always_ff @(posedge clock) begin
		if (srst) begin
			temp_irq <= 1'b0;
		end else begin
			temp_irq <= |(temp_irq_pending & ~temp_irq_mask);
		end
	end
endmodule

// *** common/onoff_pkg.sv ***
// Package for the on/off controller and sequencer: constants, states, carriers
package onoff_pkg;
	localparam int NUM_RES = 4;
	localparam int NUM_SLOTS = 4;
	localparam int DEB_W = 16;
	localparam int SEQ_W = 16;
	localparam logic [DEB_W-1:0] DEBOUNCE_CYCLES = 16'h0400;
	localparam logic [SEQ_W-1:0] SLOT_CYCLES = 16'h0800;
	localparam logic [1:0] SOFT_RESET_COLD = 2'h1;
	localparam logic [1:0] SOFT_RESET_OFF = 2'h2;
	localparam logic [1:0] TEMP_MASK_RESET = 2'h3;
	localparam logic [NUM_RES-1:0] RES_OFF = 4'h0;

	typedef enum logic [3:0] {
		st_standby,
		st_bias_enable,
		st_sw_on,
		st_power_up,
		st_hw_on,
		st_power_down,
		st_immediate_off,
		st_bias_disable
	} ctrl_state_t;

	// Analog comparator and bias handshake flags
	typedef struct packed {
		logic system_undervoltage_lockout;
		logic system_overvoltage_lockout;
		logic overtemp_lockout;
		logic temp_recovered;
		logic bias_ok;
		logic bias_off_done;
		logic temp_alarm_low;
		logic temp_alarm_high;
	} analog_flags_t;

	// Per-resource sequencing setup
	typedef struct packed {
		logic hw_sequenced;
		logic [1:0] up_slot;
		logic [1:0] down_slot;
	} res_cfg_t;

	// Wake sources and their enables
	typedef struct packed {
		logic onkey_wake_enable;
		logic charge_wake_enable;
		logic gpio_wake_enable;
		logic onkey_manual_reset_enable;
		logic gpio_manual_reset_enable;
	} wake_cfg_t;
endpackage

// *** rtl/debounce.sv ***
// Two-edge debouncer with a glitch-restarted qualification counter
`timescale 1ns/100ps
module debounce (
	input wire logic clock,
	input wire logic srst,
	input wire logic raw,
	output logic clean
);
	import onoff_pkg::*;

	logic [DEB_W-1:0] count;

	always_ff @(posedge clock) begin
		if (srst) begin
			count <= '0;
		end else if (raw == clean) begin
			count <= '0;
		end else if (count == DEBOUNCE_CYCLES - 16'h0001) begin
			count <= '0;
		end else begin
			count <= count + 16'h0001;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			clean <= 1'b0;
		end else if (raw != clean && count == DEBOUNCE_CYCLES - 16'h0001) begin
			clean <= raw;
		end
	end
endmodule

// *** sim/onoff_chk.sv ***
// Port checker for the on/off controller
`timescale 1ns/100ps
module onoff_chk (
	input wire logic clock,
	input wire logic srst,
	input wire onoff_pkg::analog_flags_t flags,
	input wire logic bias_enable_bit,
	input wire logic soft_reset_write,
	input wire logic [1:0] temp_irq_mask,
	input wire onoff_pkg::res_cfg_t [3:0] res_cfg,
	input wire logic [3:0] res_on,
	input wire logic temp_alarm_low_status,
	input wire logic [1:0] temp_irq_pending,
	input wire logic temp_irq,
	input wire logic cold_reset_wake,
	input wire onoff_pkg::ctrl_state_t state
);
	import onoff_pkg::*;
	logic [3:0] hw_mask;
	assign hw_mask = {res_cfg[3].hw_sequenced, res_cfg[2].hw_sequenced,
		res_cfg[1].hw_sequenced, res_cfg[0].hw_sequenced};
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence s_down_done;
		state == st_power_down ##1 state == st_bias_disable;
	endsequence
	a_alarm_follow: assert property (!$past(srst) |->
		temp_alarm_low_status == $past(flags.temp_alarm_low))
		else $error("alarm status does not follow its flag");
	a_irq_from_pending: assert property (!$past(srst) |->
		temp_irq == $past(|(temp_irq_pending & ~temp_irq_mask)))
		else $error("interrupt does not match unmasked pending");
	a_ovp_ignored: assert property (state == st_sw_on &&
		flags.system_overvoltage_lockout && bias_enable_bit &&
		!flags.system_undervoltage_lockout && !flags.overtemp_lockout &&
		!soft_reset_write |=> state == st_sw_on)
		else $error("overvoltage left software on state");
	a_uvlo_exit: assert property (state == st_sw_on &&
		flags.system_undervoltage_lockout |=> state != st_sw_on)
		else $error("undervoltage did not leave software on");
	a_overtemp_lockout_immediate: assert property (state == st_hw_on &&
		flags.overtemp_lockout |=> state == st_immediate_off)
		else $error("overtemp did not force immediate off");
	a_bias_on_wait: assert property (state == st_bias_enable &&
		!flags.bias_ok |=> state == st_bias_enable)
		else $error("left bias enable before bias ok");
	a_bias_off_wait: assert property (state == st_bias_disable &&
		!flags.bias_off_done |=> state == st_bias_disable)
		else $error("left bias disable before done");
	a_cold_one_pulse: assert property (cold_reset_wake |=>
		!cold_reset_wake)
		else $error("cold reset pulse longer than one cycle");
	a_down_all_off: assert property (s_down_done |->
		(res_on & hw_mask) == RES_OFF)
		else $error("power down ended with resources on");
	a_immediate_off: assert property (state == st_immediate_off ##1
		state != st_immediate_off |-> res_on == RES_OFF)
		else $error("immediate off ended with resources on");
endmodule
bind onoff_sequencer_thermal_guard onoff_chk u_chk (.clock, .srst, .flags,
	.bias_enable_bit, .soft_reset_write, .temp_irq_mask, .res_cfg, .res_on,
	.temp_alarm_low_status, .temp_irq_pending, .temp_irq,
	.cold_reset_wake, .state);

// *** sim/bias_model.sv ***
// Main bias partner that answers requests after a settling delay
`timescale 1ns/100ps
module bias_model #(
	parameter int DLY = 6
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic bias_request,
	output logic bias_ok,
	output logic bias_off_done
);
	int cnt;
	always_ff @(posedge clock) begin
		if (srst) begin
			cnt <= 0;
			bias_ok <= 1'b0;
		end else begin
			cnt <= (bias_request != bias_ok && cnt < DLY) ? cnt + 1 : 0;
			if (cnt == DLY) bias_ok <= bias_request;
		end
	end
	assign bias_off_done = !bias_ok;
endmodule

// *** sim/onoff_sequencer_thermal_guard_test.sv ***
// Bench for the on/off controller and sequencer
`timescale 1ns/100ps
module onoff_sequencer_thermal_guard_test;
	import onoff_pkg::*;
	logic clock = 1'b0, srst = 1'b1, bias_enable_bit = 1'b0;
	logic soft_reset_write = 1'b0, charge_input = 1'b0, wake = 1'b0;
	logic key_n = 1'b1, gpio = 1'b0, gpio_mr = 1'b0, cold;
	analog_flags_t fl = '0, flags;
	wake_cfg_t wake_cfg = '0;
	res_cfg_t [3:0] res_cfg = '0;
	logic [3:0] sw_enable = '0, res_on;
	logic [1:0] soft_reset_field = '0, temp_irq_clear = '0, pend;
	logic [1:0] temp_irq_mask = TEMP_MASK_RESET;
	logic req, ok, off, lo, hi, irq, blk;
	ctrl_state_t state;
	int n_fail = 0, num_checks = 0;
	initial forever #2.5 clock = ~clock;
	always_comb begin
		flags = fl;
		flags.bias_ok = ok;
		flags.bias_off_done = off;
	end
	bias_model bm (.clock, .srst, .bias_request(req), .bias_ok(ok),
		.bias_off_done(off));
	onoff_sequencer_thermal_guard dut (.clock, .srst, .flags, .wake_cfg,
		.res_cfg, .sw_enable, .bias_enable_bit, .soft_reset_field,
		.soft_reset_write, .internal_wake_flag(wake), .on_key_n(key_n),
		.charge_input, .gpio_wake(gpio), .gpio_manual_reset(gpio_mr),
		.temp_irq_mask, .temp_irq_clear, .res_on, .bias_request(req),
		.temp_alarm_low_status(lo), .temp_alarm_high_status(hi),
		.temp_irq_pending(pend), .temp_irq(irq), .overtemp_blocked(blk),
		.cold_reset_wake(cold), .state);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic wait_st(input ctrl_state_t s);
		for (int i = 0; i < 20000 && state !== s; i++) @(negedge clock);
		chk(state, s);
	endtask
	// Slot ticks are thousands of cycles apart, hence the wide bound
	task automatic wait_res(input logic [3:0] from);
		for (int i = 0; i < 5000 && res_on === from; i++) @(negedge clock);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Tests take about 47k cycles; this leaves a margin for slow waits
	initial begin
		#300000;
		n_fail++;
		end_of_test();
	end
	initial begin
		cyc(8);
		srst = 1'b0;
		cyc(1);
		chk({state, res_on, req}, 9'h000);
		$display("test reset done");
		bias_enable_bit = 1'b1;
		wait_st(st_sw_on);
		sw_enable = 4'h5;
		cyc(3);
		chk(res_on, 4'h5);
		soft_reset_field = SOFT_RESET_COLD;
		soft_reset_write = 1'b1;
		cyc(1);
		soft_reset_write = 1'b0;
		chk(cold, 1'b1);
		cyc(1);
		chk({cold, state === st_sw_on}, 2'h1);
		fl.system_overvoltage_lockout = 1'b1;
		cyc(5);
		chk(state, st_sw_on);
		fl.system_undervoltage_lockout = 1'b1;
		cyc(2);
		chk(state === st_sw_on, 1'b0);
		fl = '0;
		bias_enable_bit = 1'b0;
		sw_enable = '0;
		wait_st(st_standby);
		$display("test software on done");
		res_cfg = {5'h13, 5'h14, 5'h10, 5'h13};
		wake = 1'b1;
		cyc(1);
		wake = 1'b0;
		wait_st(st_power_up);
		wait_res(RES_OFF);
		chk(res_on, 4'hb);
		wait_res(4'hb);
		chk(res_on, 4'hf);
		wait_st(st_hw_on);
		chk(res_on, 4'hf);
		soft_reset_field = SOFT_RESET_OFF;
		soft_reset_write = 1'b1;
		cyc(1);
		soft_reset_write = 1'b0;
		wait_st(st_power_down);
		wait_res(4'hf);
		chk(res_on, 4'h9);
		wait_st(st_standby);
		chk(res_on, RES_OFF);
		$display("test sequencing done");
		wake_cfg.charge_wake_enable = 1'b1;
		charge_input = 1'b1;
		cyc(500);
		charge_input = 1'b0;
		cyc(1200);
		chk(state, st_standby);
		charge_input = 1'b1;
		wait_st(st_bias_enable);
		wait_st(st_hw_on);
		fl.overtemp_lockout = 1'b1;
		cyc(1);
		chk(state, st_immediate_off);
		wait_st(st_standby);
		chk({res_on, blk}, 5'h01);
		wake = 1'b1;
		cyc(20);
		chk(state, st_standby);
		wake = 1'b0;
		fl = 8'h10;
		cyc(5);
		chk(blk, 1'b0);
		$display("test overtemp done");
		wake_cfg.onkey_wake_enable = 1'b1;
		key_n = 1'b0;
		cyc(1000);
		chk(state, st_standby);
		wait_st(st_bias_enable);
		bias_enable_bit = 1'b1;
		key_n = 1'b1;
		wait_st(st_sw_on);
		bias_enable_bit = 1'b0;
		wait_st(st_standby);
		wake_cfg.gpio_wake_enable = 1'b1;
		wake_cfg.gpio_manual_reset_enable = 1'b1;
		gpio = 1'b1;
		wait_st(st_power_up);
		wait_st(st_hw_on);
		gpio_mr = 1'b1;
		cyc(1);
		chk(state, st_power_down);
		gpio_mr = 1'b0;
		wait_st(st_standby);
		$display("test wake pins done");
		temp_irq_mask = 2'h0;
		fl.temp_alarm_low = 1'b1;
		cyc(3);
		chk({lo, pend, irq}, 4'hb);
		temp_irq_mask = 2'h1;
		cyc(3);
		chk(irq, 1'b0);
		temp_irq_clear = 2'h1;
		cyc(1);
		chk(pend, 2'h0);
		temp_irq_clear = 2'h0;
		fl.temp_alarm_low = 1'b0;
		fl.temp_alarm_high = 1'b1;
		cyc(3);
		chk({lo, hi, pend, irq}, 5'h0f);
		$display("test alarms done");
		end_of_test();
	end
endmodule
